/* File: verilog/bpi_top.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - with stepping on, pointer advances by the count of enabled byte lanes per data access
// - receive area select picks receive area and queue packet, else packet select
// - pointer load with read bit starts prefetch; read bit low means writes
// - pointer readback gives next address the host accesses, not prefetch address
// - not-empty bit shows write fifo holds data; host loads pointer only when empty
// - early underrun bit enables detection; without stepping pointer is dword aligned
// - two 12-byte one-way fifos keep byte order for mixed sizes and alignments
// - data port decodes 8 to Bh; byte count from lane enables
// - interrupt output when any flag set with its mask bit; mask word or bytes
// - discard-count-full latches at count FF, clears only on acknowledge
// - early receive flag sets when frame bytes exceed level, held until acknowledged
// - protocol exception merges link, counter wrap and fatal transmit causes, gated
// - exception clears by link enable low, counter read, or transmitter on again
// - receive abort latches on alloc failure, oversize or drop, cleared by acknowledge
// - allocation done flag is complement of allocation failed
// - transmit drained flag latches on fifo empty, held until acknowledged
// - transmit complete is inverse of completion vacant; acknowledge pops one entry
// - receive pending is inverse of receive vacant, acknowledge has no effect
// - packet select holds transmit packet, cleared by reset and memory manager reset
module bpi_top
   import bpi_pkg::*;
#(
   parameter int FIFO_BYTES = BPI_FIFO_BYTES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] bus_addr,
   input wire logic [3:0] bus_be,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   output logic host_wait_ready,
   output logic irq,
   output logic early_underrun_detect_enable,
   output logic completion_pop,
   output bpi_mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic [5:0] rx_queue_pkt,
   input wire bpi_evt_t evt
);
   localparam int CW = $clog2(FIFO_BYTES + 1);
   localparam int IW = $clog2(FIFO_BYTES);

   logic [15:0] ptr_r;
   logic [5:0] psel_r;
   logic [7:0] mask_r;
   logic [7:0] lat_r;
   logic [2:0] eph_cause_r;
   logic [7:0] disc_prev_r;
   logic txe_prev_r;
   logic txon_prev_r;
   logic [3:0] fill_cnt_r;
   logic [18:0] wf_mem [FIFO_BYTES];
   logic [IW-1:0] wf_rd_r, wf_wr_r;
   logic [CW-1:0] wf_cnt_r;
   logic [7:0] rf_mem [FIFO_BYTES];
   logic [IW-1:0] rf_rd_r, rf_wr_r;
   logic [CW-1:0] rf_cnt_r;
   logic [10:0] pf_ptr_r;
   logic pf_on_r, drop_r;
   bpi_mem_st_t st_r;

   // bus decode
   logic w_psel, w_ptr_lo, w_ptr_hi, ptr_load, d_wr, d_rd, w_ack, w_mask_lo;
   logic [2:0] nbytes;
   logic [7:0] flags;
   assign w_psel = bus_wr && bus_addr[3:2] == BPI_OFS_PSEL[3:2] && bus_be[2];
   assign w_ptr_lo = bus_wr && bus_addr[3:2] == BPI_OFS_PTR[3:2] && bus_be[2];
   assign w_ptr_hi = bus_wr && bus_addr[3:2] == BPI_OFS_PTR[3:2] && bus_be[3];
   assign ptr_load = w_ptr_hi; // high byte completes the load
   assign d_wr = bus_wr && bus_addr[3:2] == BPI_OFS_DATA[3:2] && bus_be != 4'h0;
   assign d_rd = bus_rd && bus_addr[3:2] == BPI_OFS_DATA[3:2] && bus_be != 4'h0;
   assign w_ack = bus_wr && bus_addr[3:2] == BPI_OFS_FLAGS[3:2] && bus_be[0];
   assign w_mask_lo = bus_wr && bus_addr[3:2] == BPI_OFS_MASK[3:2] && bus_be[1];
   // byte count of a data access from the lane enables
   assign nbytes = 3'(bus_be[0]) + 3'(bus_be[1]) + 3'(bus_be[2]) + 3'(bus_be[3]);

   // status view: latched flags plus live ones
   always_comb begin
      flags = lat_r;
      flags[BPI_F_EPH] = (eph_cause_r[0] & evt.link_event_enable)
                       | (eph_cause_r[1] & evt.counter_wrap_enable)
                       | (eph_cause_r[2] & evt.transmit_fault_enable);
      flags[BPI_F_ALLOC] = ~evt.alloc_failed;
      flags[BPI_F_TXC] = ~evt.completion_queue_vacant;
      flags[BPI_F_RCV] = ~evt.receive_queue_vacant;
   end

   // pointer register: control bits and host-visible address
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_r <= BPI_PTR_RST;
      end else begin
         if (w_ptr_lo) begin
            ptr_r[7:0] <= bus_wdata[23:16];
         end
         if (w_ptr_hi) begin
            ptr_r[15:12] <= bus_wdata[31:28];
            ptr_r[10:8] <= bus_wdata[26:24];
         end else if ((d_wr || d_rd) && ptr_r[BPI_PTR_STEP]) begin
            ptr_r[10:0] <= ptr_r[10:0] + 11'(nbytes);
         end
         ptr_r[BPI_PTR_NE] <= 1'b0;
      end
   end

   // packet select, cleared also by memory manager reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         psel_r <= BPI_PSEL_RST;
      end else if (evt.mmu_reset) begin
         psel_r <= BPI_PSEL_RST;
      end else if (w_psel) begin
         psel_r <= bus_wdata[21:16];
      end
   end

   // mask register, word or byte wide
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_r <= BPI_MASK_RST;
      end else if (w_mask_lo) begin
         mask_r <= bus_wdata[15:8];
      end
   end

   // write fifo: host pushes bytes in lane order, engine drains
   logic wf_pop, rf_push, rf_flush;
   logic [IW-1:0] wf_idx;
   logic [CW-1:0] wf_room;
   assign wf_room = CW'(FIFO_BYTES) - wf_cnt_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wf_wr_r <= '0;
         wf_rd_r <= '0;
         wf_cnt_r <= '0;
      end else begin
         if (d_wr && !ptr_r[BPI_PTR_READ] && CW'(nbytes) <= wf_room) begin
            wf_wr_r <= IW'((32'(wf_wr_r) + 32'(nbytes)) % FIFO_BYTES);
         end
         if (wf_pop) begin
            wf_rd_r <= IW'((32'(wf_rd_r) + 1) % FIFO_BYTES);
         end
         wf_cnt_r <= wf_cnt_r + ((d_wr && !ptr_r[BPI_PTR_READ] && CW'(nbytes) <= wf_room)
                     ? CW'(nbytes) : CW'(0)) - CW'(wf_pop);
      end
   end

   // write fifo storage, each byte tagged with its buffer address
   always_ff @(posedge clk) begin
      logic [2:0] k;
      k = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (d_wr && !ptr_r[BPI_PTR_READ] && bus_be[i] && CW'(nbytes) <= wf_room) begin
            wf_mem[IW'((32'(wf_wr_r) + 32'(k)) % FIFO_BYTES)] <=
               {ptr_r[10:0] + 11'(k), bus_wdata[8*i +: 8]};
            k = k + 3'h1;
         end
      end
   end
   assign wf_idx = wf_rd_r;

   // read fifo: engine pushes prefetched bytes, host pops in order
   logic rd_ok;
   assign rd_ok = d_rd && CW'(nbytes) <= rf_cnt_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rf_wr_r <= '0;
         rf_rd_r <= '0;
         rf_cnt_r <= '0;
      end else if (rf_flush) begin
         rf_wr_r <= '0;
         rf_rd_r <= '0;
         rf_cnt_r <= '0;
      end else begin
         if (rf_push) begin
            rf_wr_r <= IW'((32'(rf_wr_r) + 1) % FIFO_BYTES);
         end
         if (rd_ok) begin
            rf_rd_r <= IW'((32'(rf_rd_r) + 32'(nbytes)) % FIFO_BYTES);
         end
         rf_cnt_r <= rf_cnt_r + CW'(rf_push) - (rd_ok ? CW'(nbytes) : CW'(0));
      end
   end
   always_ff @(posedge clk) begin
      if (rf_push) begin
         rf_mem[rf_wr_r] <= mem_rdata;
      end
   end

   // refetch on pointer load, or after each read when stepping is off
   assign rf_flush = ptr_load || (d_rd && !ptr_r[BPI_PTR_STEP]);
   assign wf_pop = st_r == BPI_WR && mem_ack;
   assign rf_push = st_r == BPI_RD && mem_ack && !drop_r && !rf_flush;

   // memory engine: drain writes first, then keep the read fifo topped up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= BPI_IDLE;
         mem_req <= '0;
         pf_ptr_r <= '0;
         pf_on_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         if (ptr_load) begin
            pf_ptr_r <= {bus_wdata[26:24], w_ptr_lo ? bus_wdata[23:16] : ptr_r[7:0]};
            pf_on_r <= bus_wdata[29];
         end else if (rf_flush) begin
            pf_ptr_r <= ptr_r[10:0];
         end
         if (rf_flush && st_r == BPI_RD && !mem_ack) begin
            drop_r <= 1'b1;
         end
         case (st_r)
            BPI_IDLE: begin
               drop_r <= 1'b0;
               mem_req.rx <= ptr_r[BPI_PTR_RX];
               mem_req.pkt <= ptr_r[BPI_PTR_RX] ? rx_queue_pkt : psel_r;
               if (wf_cnt_r != '0) begin
                  mem_req.req <= 1'b1;
                  mem_req.we <= 1'b1;
                  {mem_req.addr, mem_req.wdata} <= wf_mem[wf_idx];
                  st_r <= BPI_WR;
               end else if (pf_on_r && ptr_r[BPI_PTR_READ] && !rf_flush
                            && rf_cnt_r < CW'(FIFO_BYTES)) begin
                  mem_req.req <= 1'b1;
                  mem_req.we <= 1'b0;
                  mem_req.addr <= pf_ptr_r;
                  st_r <= BPI_RD;
               end
            end
            BPI_WR: begin
               if (mem_ack) begin
                  mem_req.req <= 1'b0;
                  st_r <= BPI_IDLE;
               end
            end
            BPI_RD: begin
               if (mem_ack) begin
                  mem_req.req <= 1'b0;
                  if (!drop_r && !rf_flush) begin
                     pf_ptr_r <= pf_ptr_r + 11'h1;
                  end
                  st_r <= BPI_IDLE;
               end
            end
            default: begin
               st_r <= BPI_IDLE;
               mem_req <= '0;
            end
         endcase
      end
   end

   // wait-ready: low for BPI_FILL_CYC cycles after a pointer load with the read bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fill_cnt_r <= '0;
         host_wait_ready <= 1'b1;
      end else begin
         if (ptr_load && bus_wdata[29]) begin
            fill_cnt_r <= 4'(BPI_FILL_CYC);
         end else if (fill_cnt_r != '0) begin
            fill_cnt_r <= fill_cnt_r - 4'h1;
         end
         host_wait_ready <= !(ptr_load && bus_wdata[29]) && fill_cnt_r <= 4'h1;
      end
   end

   // sticky flags: a set in the same cycle as its acknowledge wins
   logic ack_disc, ack_ercv, ack_abrt, ack_txe;
   assign ack_disc = w_ack && bus_wdata[BPI_F_DISC];
   assign ack_ercv = w_ack && bus_wdata[BPI_F_ERCV];
   assign ack_abrt = w_ack && bus_wdata[BPI_F_ABRT];
   assign ack_txe = w_ack && bus_wdata[BPI_F_TXE];
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lat_r <= '0;
         disc_prev_r <= '0;
         txe_prev_r <= 1'b0;
      end else begin
         disc_prev_r <= evt.disc_count;
         txe_prev_r <= evt.tx_fifo_empty;
         if (evt.disc_count == BPI_DISC_FULL && disc_prev_r != BPI_DISC_FULL) begin
            lat_r[BPI_F_DISC] <= 1'b1;
         end else if (ack_disc) begin
            lat_r[BPI_F_DISC] <= 1'b0;
         end
         if (evt.rx_active && 16'(evt.rx_bytes) >
             (16'(evt.early_receive_level) << BPI_ERCV_LG2)) begin
            lat_r[BPI_F_ERCV] <= 1'b1;
         end else if (ack_ercv) begin
            lat_r[BPI_F_ERCV] <= 1'b0;
         end
         if (evt.abort_alloc || evt.abort_long || evt.receive_drop_request) begin
            lat_r[BPI_F_ABRT] <= 1'b1;
         end else if (ack_abrt) begin
            lat_r[BPI_F_ABRT] <= 1'b0;
         end
         if (evt.tx_fifo_empty && !txe_prev_r) begin
            lat_r[BPI_F_TXE] <= 1'b1;
         end else if (ack_txe) begin
            lat_r[BPI_F_TXE] <= 1'b0;
         end
      end
   end

   // protocol exception causes, each with its own clearing path
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         eph_cause_r <= '0;
         txon_prev_r <= 1'b0;
      end else begin
         txon_prev_r <= evt.transmitter_on;
         if (evt.link_evt) begin
            eph_cause_r[0] <= 1'b1;
         end else if (!evt.link_event_enable) begin
            eph_cause_r[0] <= 1'b0;
         end
         if (evt.wrap_evt) begin
            eph_cause_r[1] <= 1'b1;
         end else if (evt.counter_read) begin
            eph_cause_r[1] <= 1'b0;
         end
         if (evt.tx_fatal != 5'h00) begin
            eph_cause_r[2] <= 1'b1;
         end else if (evt.transmitter_on && !txon_prev_r) begin
            eph_cause_r[2] <= 1'b0;
         end
      end
   end

   // read data, interrupt and side outputs, all registered
   logic [31:0] rd_nxt;
   always_comb begin
      logic [2:0] k;
      k = 3'h0;
      rd_nxt = '0;
      case (bus_addr[3:2])
         BPI_OFS_PSEL[3:2]: rd_nxt[21:16] = psel_r;
         BPI_OFS_PTR[3:2]: begin
            rd_nxt[31:16] = ptr_r;
            rd_nxt[16 + BPI_PTR_NE] = wf_cnt_r != '0;
         end
         BPI_OFS_DATA[3:2]: begin
            for (int i = 0; i < 4; i++) begin
               if (bus_be[i]) begin
                  rd_nxt[8*i +: 8] = rf_mem[IW'((32'(rf_rd_r) + 32'(k)) % FIFO_BYTES)];
                  k = k + 3'h1;
               end
            end
         end
         BPI_OFS_FLAGS[3:2]: rd_nxt[15:0] = {mask_r, flags};
         default: rd_nxt = '0;
      endcase
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= '0;
         irq <= 1'b0;
         early_underrun_detect_enable <= 1'b0;
         completion_pop <= 1'b0;
      end else begin
         if (bus_rd) begin
            bus_rdata <= rd_nxt;
         end
         irq <= |(flags & mask_r);
         early_underrun_detect_enable <= ptr_r[BPI_PTR_EUD];
         completion_pop <= w_ack && bus_wdata[BPI_F_TXC];
      end
   end
endmodule : bpi_top

/* File: verilog/bpi_pkg.sv */
package bpi_pkg;
   // register byte addresses on the host port
   localparam logic [3:0] BPI_OFS_PSEL = 4'h2;
   localparam logic [3:0] BPI_OFS_PTR = 4'h6;
   localparam logic [3:0] BPI_OFS_DATA = 4'h8;
   localparam logic [3:0] BPI_OFS_FLAGS = 4'hc;
   localparam logic [3:0] BPI_OFS_MASK = 4'hd;
   // pointer register field positions
   localparam int BPI_PTR_RX = 15;
   localparam int BPI_PTR_STEP = 14;
   localparam int BPI_PTR_READ = 13;
   localparam int BPI_PTR_EUD = 12;
   localparam int BPI_PTR_NE = 11;
   localparam int BPI_AW = 11;
   // status flag bit positions
   localparam int BPI_F_DISC = 7;
   localparam int BPI_F_ERCV = 6;
   localparam int BPI_F_EPH = 5;
   localparam int BPI_F_ABRT = 4;
   localparam int BPI_F_ALLOC = 3;
   localparam int BPI_F_TXE = 2;
   localparam int BPI_F_TXC = 1;
   localparam int BPI_F_RCV = 0;
   // reset values
   localparam logic [15:0] BPI_PTR_RST = 16'h0000;
   localparam logic [7:0] BPI_MASK_RST = 8'h00;
   localparam logic [5:0] BPI_PSEL_RST = 6'h00;
   // sizes and levels
   localparam int BPI_FIFO_BYTES = 12;
   localparam logic [7:0] BPI_DISC_FULL = 8'hff;
   localparam int BPI_ERCV_LG2 = 6;
   // read fifo fill time after a pointer load
   localparam int BPI_CLK_NS = 40;
   localparam int BPI_FILL_NS = 370;
   localparam int BPI_FILL_CYC = (BPI_FILL_NS + BPI_CLK_NS - 1) / BPI_CLK_NS;

   typedef enum {BPI_IDLE, BPI_WR, BPI_RD} bpi_mem_st_t;

   // byte request toward packet memory
   typedef struct packed {
      logic req;
      logic we;
      logic rx;
      logic [5:0] pkt;
      logic [10:0] addr;
      logic [7:0] wdata;
   } bpi_mem_req_t;

   // events from the rest of the controller, all on clk
   typedef struct packed {
      logic [7:0] disc_count;
      logic rx_active;
      logic [10:0] rx_bytes;
      logic [4:0] early_receive_level;
      logic link_evt;
      logic wrap_evt;
      logic [4:0] tx_fatal;
      logic link_event_enable;
      logic counter_wrap_enable;
      logic transmit_fault_enable;
      logic counter_read;
      logic transmitter_on;
      logic abort_alloc;
      logic abort_long;
      logic receive_drop_request;
      logic alloc_failed;
      logic tx_fifo_empty;
      logic completion_queue_vacant;
      logic receive_queue_vacant;
      logic mmu_reset;
   } bpi_evt_t;
endpackage : bpi_pkg

/* File: bench/bpi_top_chk.sv */
`timescale 1ns/1ps
module bpi_top_chk
   import bpi_pkg::*;
#(
   parameter int FIFO_BYTES = 12
) (
   input logic clk,
   input logic arst_n,
   input logic [3:0] bus_addr,
   input logic [3:0] bus_be,
   input logic [31:0] bus_wdata,
   input logic bus_wr,
   input logic bus_rd,
   input logic [31:0] bus_rdata,
   input logic host_wait_ready,
   input logic irq,
   input logic early_underrun_detect_enable,
   input logic completion_pop,
   input bpi_mem_req_t mem_req,
   input logic mem_ack,
   input logic [7:0] mem_rdata,
   input logic [5:0] rx_queue_pkt,
   input bpi_evt_t evt
);
   logic [7:0] mask_r;
   logic [5:0] psel_r;
   logic pop_r;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // shadows of mask, packet select and acknowledge writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_r <= 8'h00;
         psel_r <= 6'h00;
         pop_r <= 1'b0;
      end else begin
         pop_r <= bus_wr && bus_addr[3:2] == 2'd3 && bus_be[0] && bus_wdata[1];
         if (bus_wr && bus_addr[3:2] == 2'd3 && bus_be[1]) begin
            mask_r <= bus_wdata[15:8];
         end
         if (evt.mmu_reset) begin
            psel_r <= 6'h00;
         end else if (bus_wr && bus_addr[3:2] == 2'd0 && bus_be[2]) begin
            psel_r <= bus_wdata[21:16];
         end
      end
   end
   sequence s_ptr_load;
      bus_wr && bus_addr[3:2] == 2'd1 && bus_be[3];
   endsequence
   sequence s_fill;
      !host_wait_ready [*8] ##1 !host_wait_ready [*2] ##1 host_wait_ready;
   endsequence
   property p_fill;
      s_ptr_load ##0 bus_wdata[29] |=> s_fill;
   endproperty
   a_fill: assert property (p_fill) else $error("fill wait wrong");
   property p_eud;
      s_ptr_load |=> ##1 early_underrun_detect_enable == $past(bus_wdata[28], 2);
   endproperty
   a_eud: assert property (p_eud) else $error("underrun enable wrong");
   property p_pop;
      completion_pop == pop_r;
   endproperty
   a_pop: assert property (p_pop) else $error("completion pop wrong");
   property p_mask0;
      (mask_r == 8'h00) [*2] |-> !irq;
   endproperty
   a_mask0: assert property (p_mask0) else $error("irq while masked");
   property p_rcv;
      (mask_r[0] && !evt.receive_queue_vacant) [*3] |-> irq;
   endproperty
   a_rcv: assert property (p_rcv) else $error("no irq for receive");
   property p_alloc;
      (mask_r[3] && !evt.alloc_failed) [*3] |-> irq;
   endproperty
   a_alloc: assert property (p_alloc) else $error("no irq for alloc");
   property p_pkt;
      mem_req.req |-> mem_req.pkt == (mem_req.rx ? rx_queue_pkt : psel_r);
   endproperty
   a_pkt: assert property (p_pkt) else $error("wrong packet number");
   property p_hold;
      mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req);
   endproperty
   a_hold: assert property (p_hold) else $error("memory request moved");
endmodule : bpi_top_chk

bind bpi_top bpi_top_chk #(.FIFO_BYTES(FIFO_BYTES)) i_bpi_top_chk (
   .clk, .arst_n, .bus_addr, .bus_be, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
   .host_wait_ready, .irq, .early_underrun_detect_enable, .completion_pop,
   .mem_req, .mem_ack, .mem_rdata, .rx_queue_pkt, .evt
);

/* File: bench/bpi_mem_model.sv */
`timescale 1ns/1ps
module bpi_mem_model
   import bpi_pkg::*;
(
   input logic clk,
   input logic arst_n,
   input bpi_mem_req_t mem_req,
   input logic slow,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] ram [0:4095];
   logic [1:0] wait_r;
   // one byte per request, answered at once or after three idle cycles
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         wait_r <= 2'd0;
         mem_rdata <= 8'h00;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata; // no valid byte outside the ack cycle
         if (mem_req.req && !mem_ack) begin
            wait_r <= wait_r + 2'd1;
            if (!slow || wait_r == 2'd3) begin
               mem_ack <= 1'b1;
               wait_r <= 2'd0;
               if (mem_req.we) begin
                  ram[{mem_req.rx, mem_req.addr}] <= mem_req.wdata;
               end else begin
                  mem_rdata <= ram[{mem_req.rx, mem_req.addr}];
               end
            end
         end
      end
   end
endmodule : bpi_mem_model

/* File: bench/buffer_port_and_interrupts_bench.sv */
`timescale 1ns/1ps
module buffer_port_and_interrupts_bench
   import bpi_pkg::*;
();
   typedef struct {logic [31:0] d; logic [31:0] m;} bpi_note_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] bus_addr = 4'h0;
   logic [3:0] bus_be = 4'h0;
   logic [31:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] bus_rdata;
   logic host_wait_ready;
   logic irq;
   logic early_underrun_detect_enable;
   logic completion_pop;
   bpi_mem_req_t mem_req;
   logic mem_ack;
   logic [7:0] mem_rdata;
   logic [5:0] rx_queue_pkt = 6'h00;
   logic slow = 1'b0;
   bpi_evt_t evt;
   bpi_evt_t m_le;
   bpi_evt_t m_cr;
   bpi_evt_t m_ton;
   bpi_note_t note_q[$];
   logic [7:0] byte_q[$];
   logic [31:0] seed = 32'hbc962222;
   logic rd_seen = 1'b0;
   logic [3:0] pa [5] = '{4'h8, 4'h8, 4'h9, 4'ha, 4'ha};
   logic [3:0] pb [5] = '{4'hf, 4'h3, 4'h2, 4'hc, 4'h8};
   int error_cnt = 0;
   int samples_checked = 0;
   int i;

   bpi_top #(.FIFO_BYTES(BPI_FIFO_BYTES)) i_bpi_top (
      .clk, .arst_n, .bus_addr, .bus_be, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
      .host_wait_ready, .irq, .early_underrun_detect_enable, .completion_pop,
      .mem_req, .mem_ack, .mem_rdata, .rx_queue_pkt, .evt
   );
   bpi_mem_model i_bpi_mem_model (.clk, .arst_n, .mem_req, .slow, .mem_ack, .mem_rdata);

   // clock
   initial begin
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic give_verdict;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic cmp(input logic [31:0] got, input bpi_note_t n);
      samples_checked++;
      if ((got & n.m) !== (n.d & n.m)) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, n.d);
         error_cnt++;
      end
   endtask : cmp

   task automatic chk_lvl(input bit which, input logic e);
      logic g;
      @(negedge clk);
      g = which ? early_underrun_detect_enable : irq;
      cmp({31'h0, g}, '{{31'h0, e}, 32'h1});
      @(posedge clk);
   endtask : chk_lvl

   // oldest note is compared against each read answer
   always @(posedge clk) begin
      if (rd_seen) cmp(bus_rdata, note_q.pop_front());
      rd_seen <= bus_rd;
   end

   task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
      bus_addr <= a;
      bus_be <= be;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d,
                     input logic [31:0] m);
      note_q.push_back('{d, m});
      bus_addr <= a;
      bus_be <= be;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic dwr(input logic [3:0] a, input logic [3:0] be);
      logic [31:0] d;
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         d[8*k +: 8] = seed[7:0];
         if (be[k]) byte_q.push_back(seed[7:0]);
      end
      wr(a, be, d);
   endtask : dwr

   task automatic drd(input logic [3:0] a, input logic [3:0] be);
      logic [31:0] d = 32'h0;
      logic [31:0] m = 32'h0;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            d[8*k +: 8] = byte_q.pop_front();
            m[8*k +: 8] = 8'hff;
         end
      end
      rd(a, be, d, m);
   endtask : drd

   task automatic wait_ne;
      for (i = 0; i < 60; i++) begin
         rd(4'h4, 4'hc, 32'h0, 32'h0);
         if (bus_rdata[27] === 1'b0) break;
      end
      if (i == 60) error_cnt++;
      if (i == 60) give_verdict();
   endtask : wait_ne

   task automatic wait_rdy;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         if (host_wait_ready === 1'b1) break;
      end
      // leave room for a slow memory to fill the whole prefetch
      repeat (80) @(posedge clk);
      if (i == 40) error_cnt++;
      if (i == 40) give_verdict();
   endtask : wait_rdy

   task automatic pulse(input bpi_evt_t m);
      evt <= evt ^ m;
      @(posedge clk);
      evt <= evt ^ m;
   endtask : pulse

   // k: 0 cleared by acknowledge, 1 cleared by c, 2 level following s
   task automatic flag_case(input bpi_evt_t s, input bpi_evt_t c, input int b, input int k);
      logic [31:0] bm = 32'h1 << b;
      if (k == 2) evt <= evt ^ s;
      else pulse(s);
      if (k == 2) @(posedge clk);
      rd(4'hc, 4'h1, bm, bm);
      chk_lvl(1'b0, b != 7);
      wr(4'hc, 4'h1, k == 0 ? ~bm : 32'hff);
      rd(4'hc, 4'h1, bm, bm);
      if (k == 0) begin
         wr(4'hc, 4'h1, bm);
      end else if (k == 1) begin
         pulse(c);
      end else begin
         evt <= evt ^ s;
      end
      @(posedge clk);
      rd(4'hc, 4'h1, 32'h0, bm);
   endtask : flag_case

   // main sequence
   initial begin
      evt = '0;
      evt.rx_bytes = 11'd65;
      evt.early_receive_level = 5'd1;
      evt.link_event_enable = 1'b1;
      evt.counter_wrap_enable = 1'b1;
      evt.transmit_fault_enable = 1'b1;
      evt.alloc_failed = 1'b1;
      evt.completion_queue_vacant = 1'b1;
      evt.receive_queue_vacant = 1'b1;
      m_le = '0;
      m_le.link_event_enable = 1'b1;
      m_cr = '0;
      m_cr.counter_read = 1'b1;
      m_ton = '0;
      m_ton.transmitter_on = 1'b1;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h4, 4'hc, 32'h0, 32'hffff0000);
      rd(4'hd, 4'h2, 32'h0, 32'hff00);
      rd(4'h0, 4'hf, 32'h0, 32'hffffffff);
      seed = lfsr(seed);
      wr(4'h2, 4'h4, {10'h0, seed[5:0], 16'h0});
      rd(4'h0, 4'hf, {10'h0, seed[5:0], 16'h0}, 32'hffffffff);
      wr(4'h4, 4'hc, 32'h4000_0000);
      chk_lvl(1'b1, 1'b0);
      for (i = 0; i < 5; i++) dwr(pa[i], pb[i]);
      wait_ne();
      rd(4'h4, 4'hc, 32'h400a_0000, 32'hffff_0000);
      slow <= 1'b1;
      wr(4'h6, 4'h4, 32'h0);
      wr(4'h7, 4'h8, 32'h6000_0000);
      wait_rdy();
      for (i = 0; i < 5; i++) drd(pa[i], pb[i]);
      rd(4'h4, 4'hc, 32'h600a_0000, 32'hffff_0000);
      seed = lfsr(seed);
      rx_queue_pkt <= seed[5:0];
      wr(4'h4, 4'hc, 32'hd000_0000);
      chk_lvl(1'b1, 1'b1);
      dwr(4'h8, 4'hf);
      wait_ne();
      // no stepping: every dword read refetches the same receive bytes
      wr(4'h4, 4'hc, 32'ha000_0000);
      wait_rdy();
      for (int k = 0; k < 4; k++) byte_q.push_back(byte_q[k]);
      drd(4'h8, 4'hf);
      wait_rdy();
      drd(4'h8, 4'hf);
      rd(4'h4, 4'hc, 32'ha000_0000, 32'hffff_0000);
      pulse(bpi_evt_t'{mmu_reset: 1'b1, default: '0});
      rd(4'h0, 4'h4, 32'h0, 32'h3f_0000);
      wr(4'hd, 4'h2, 32'h7f00);
      rd(4'hd, 4'h2, 32'h7f00, 32'hff00);
      flag_case(bpi_evt_t'{disc_count: 8'hff, default: '0}, '0, 7, 0);
      flag_case(bpi_evt_t'{rx_active: 1'b1, default: '0}, '0, 6, 0);
      flag_case(bpi_evt_t'{abort_alloc: 1'b1, default: '0}, '0, 4, 0);
      flag_case(bpi_evt_t'{abort_long: 1'b1, default: '0}, '0, 4, 0);
      flag_case(bpi_evt_t'{receive_drop_request: 1'b1, default: '0}, '0, 4, 0);
      flag_case(bpi_evt_t'{tx_fifo_empty: 1'b1, default: '0}, '0, 2, 0);
      flag_case(bpi_evt_t'{link_evt: 1'b1, default: '0}, m_le, 5, 1);
      flag_case(bpi_evt_t'{wrap_evt: 1'b1, default: '0}, m_cr, 5, 1);
      for (i = 0; i < 5; i++) begin
         flag_case(bpi_evt_t'{tx_fatal: 5'(1 << i), default: '0}, m_ton, 5, 1);
      end
      flag_case(bpi_evt_t'{alloc_failed: 1'b1, default: '0}, '0, 3, 2);
      flag_case(bpi_evt_t'{completion_queue_vacant: 1'b1, default: '0}, '0, 1, 2);
      flag_case(bpi_evt_t'{receive_queue_vacant: 1'b1, default: '0}, '0, 0, 2);
      repeat (2) @(posedge clk);
      give_verdict();
   end
endmodule : buffer_port_and_interrupts_bench
